// ### sea_pkg.sv
/*
  constants shared by the sram error alarm block: register offsets,
  field positions, reset values, error-info codes and bus answers.
  assumes a 32-bit axi4-lite register bus with byte addresses.
*/
package sea_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MEM_AW = 10;
  localparam logic [MEM_AW-1:0] MEM_LAST = 10'h3FF;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DETECT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FAULT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_INFO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;

  localparam int unsigned CTRL_FWD = 0;
  localparam int unsigned CTRL_START = 1;
  localparam int unsigned CTRL_ABORT = 2;
  localparam logic CTRL_FWD_RST = 1'b1;

  localparam int unsigned DET_W = 4;
  localparam int unsigned DET_CE = 0;
  localparam int unsigned DET_UE = 1;
  localparam int unsigned DET_AE = 2;
  localparam int unsigned DET_INIT = 3;
  localparam logic [DET_W-1:0] DET_RST = 4'h0;
  localparam logic [DET_W-1:0] MASK_RST = 4'h0;

  localparam int unsigned OPERATION_ERROR_BITS_W = 4;
  localparam int unsigned OPERATION_ERROR_BITS_CRIT_UE = 0;
  localparam int unsigned OPERATION_ERROR_BITS_UE = 1;
  localparam int unsigned OPERATION_ERROR_BITS_AE = 2;
  localparam int unsigned OPERATION_ERROR_BITS_CE = 3;
  localparam logic [OPERATION_ERROR_BITS_W-1:0] OPERATION_ERROR_BITS_RST = 4'h0;

  localparam int unsigned INFO_W = MEM_AW + 2;
  localparam logic [1:0] INFO_CE = 2'h1;
  localparam logic [1:0] INFO_UE = 2'h2;
  localparam logic [1:0] INFO_AE = 2'h3;
  localparam logic [INFO_W-1:0] INFO_RST = 12'h000;

  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_TEST = 1;
  localparam int unsigned STAT_MAP = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sea_pkg

// ### sea_init.sv
/*
  memory initialization sequencer: sweeps every word of the guarded
  sram with a write strobe, can be aborted at any cycle.
  assumes the sram takes one initialization write per cycle.
*/
module sea_init (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic [sea_pkg::MEM_AW-1:0] addr,
  output logic done
);
  typedef enum logic [0:0] {
    SEA_IDLE = 1'b0,
    SEA_RUN = 1'b1
  } sea_init_state_t;

  sea_init_state_t state_q;
  logic [sea_pkg::MEM_AW-1:0] addr_q;
  logic done_q;

  assign busy = (state_q == SEA_RUN);
  assign addr = addr_q;
  assign done = done_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SEA_IDLE;
      addr_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        SEA_IDLE:
        begin
          if (start && !abort)
          begin
            state_q <= SEA_RUN;
            addr_q <= '0;
          end
        end
        SEA_RUN:
        begin
          if (abort)
          begin
            state_q <= SEA_IDLE;
          end
          else if (addr_q == sea_pkg::MEM_LAST)
          begin
            state_q <= SEA_IDLE;
            done_q <= 1'b1;
          end
          else
          begin
            addr_q <= addr_q + 1'b1;
          end
        end
        default:
        begin
          state_q <= SEA_IDLE;
        end
      endcase
    end
  end
endmodule : sea_init

// ### sea_guard.sv
/*
  memory guard for one sram: checks each read for correctable and
  uncorrectable errors and each access for address errors while app_reset is low, keeps sticky status, pulses alarms
  to the safety alarm collector and to the owning module, and runs the
  memory initialization. registers sit behind an axi4-lite slave.
  assumes the sram checker signals come from logic on aclk, and that
  memory_self_test and memory_map_select come from another domain.
*/
module sea_guard (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sea_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sea_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sea_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sea_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_access,
  input wire logic mem_write,
  input wire logic [sea_pkg::MEM_AW-1:0] mem_addr,
  input wire logic ecc_correctable,
  input wire logic ecc_uncorrectable,
  input wire logic address_fault,
  input wire logic cpu_data_memory,
  input wire logic app_reset,
  input wire logic memory_self_test,
  input wire logic memory_map_select,
  output logic alarm_correctable,
  output logic alarm_uncorrectable,
  output logic alarm_address,
  output logic alarm_group0_flag10,
  output logic alarm_group1_flag10,
  output logic owner_correctable,
  output logic owner_uncorrectable,
  output logic owner_address,
  output logic init_busy,
  output logic [sea_pkg::MEM_AW-1:0] init_addr,
  output logic irq
);
  // register state
  logic fwd_q;
  logic [sea_pkg::DET_W-1:0] detect_q;
  logic [sea_pkg::DET_W-1:0] mask_q;
  logic [sea_pkg::OPERATION_ERROR_BITS_W-1:0] operation_error_bits_q;
  logic [sea_pkg::INFO_W-1:0] info_q;
  logic start_q;
  logic abort_q;
  logic boot_q;
  logic irq_q;

  // alarm and owner pulses
  logic al_ce_q;
  logic al_ue_q;
  logic al_ae_q;
  logic al_g10_q;
  logic own_ce_q;
  logic own_ue_q;
  logic own_ae_q;

  // pin synchronisers for self-test and memory map switches
  logic test_s1_q;
  logic test_s2_q;
  logic test_s3_q;
  logic map_s1_q;
  logic map_s2_q;
  logic map_s3_q;

  // bus slave state
  logic aw_full_q;
  logic w_full_q;
  logic [sea_pkg::ADDR_W-1:0] aw_addr_q;
  logic [sea_pkg::DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [sea_pkg::DATA_W-1:0] rdata_q;

  // init engine
  logic ini_busy;
  logic [sea_pkg::MEM_AW-1:0] ini_addr;
  logic ini_done;

  // access checking; the map select never blocks accesses, so a mapped
  // cache still serves as cache
  wire acc_ok = mem_access && !app_reset;
  wire ev_ce = acc_ok && !mem_write && ecc_correctable;
  wire ev_ue = acc_ok && !mem_write && ecc_uncorrectable;
  wire ev_ae = acc_ok && address_fault;
  wire ev_crit = ev_ue && cpu_data_memory;
  wire [sea_pkg::DET_W-1:0] det_set = {ini_done, ev_ae, ev_ue, ev_ce};
  wire [sea_pkg::OPERATION_ERROR_BITS_W-1:0] operation_error_bits_set = {ev_ce, ev_ae, ev_ue && !cpu_data_memory, ev_crit};
  wire [1:0] info_code = ev_ae ? sea_pkg::INFO_AE : (ev_ue ? sea_pkg::INFO_UE : sea_pkg::INFO_CE);
  wire any_ev = ev_ce || ev_ue || ev_ae;

  // self-test or mapping switch detection
  wire test_edge = test_s2_q ^ test_s3_q;
  wire map_edge = map_s2_q ^ map_s3_q;
  wire ini_start = boot_q || start_q || test_edge || map_edge;

  // write channel decode
  wire aw_take = s_axi_awvalid && !aw_full_q;
  wire w_take = s_axi_wvalid && !w_full_q;
  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  wire wlo = wr_go && w_strb_q[0];
  wire wa_ctrl = (aw_addr_q == sea_pkg::OFF_CTRL);
  wire wa_det = (aw_addr_q == sea_pkg::OFF_DETECT);
  wire wa_flt = (aw_addr_q == sea_pkg::OFF_FAULT);
  wire wa_mask = (aw_addr_q == sea_pkg::OFF_MASK);
  wire wa_info = (aw_addr_q == sea_pkg::OFF_INFO);
  wire wa_stat = (aw_addr_q == sea_pkg::OFF_STAT);
  wire wa_hit = wa_ctrl || wa_det || wa_flt || wa_mask || wa_info || wa_stat;
  wire [sea_pkg::DET_W-1:0] det_clr = (wlo && wa_det) ? w_data_q[sea_pkg::DET_W-1:0] : '0;
  wire [sea_pkg::OPERATION_ERROR_BITS_W-1:0] operation_error_bits_clr = (wlo && wa_flt) ? w_data_q[sea_pkg::OPERATION_ERROR_BITS_W-1:0] : '0;

  // read channel decode
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire ra_ctrl = (s_axi_araddr == sea_pkg::OFF_CTRL);
  wire ra_det = (s_axi_araddr == sea_pkg::OFF_DETECT);
  wire ra_flt = (s_axi_araddr == sea_pkg::OFF_FAULT);
  wire ra_mask = (s_axi_araddr == sea_pkg::OFF_MASK);
  wire ra_info = (s_axi_araddr == sea_pkg::OFF_INFO);
  wire ra_stat = (s_axi_araddr == sea_pkg::OFF_STAT);
  wire ra_hit = ra_ctrl || ra_det || ra_flt || ra_mask || ra_info || ra_stat;
  wire [sea_pkg::DATA_W-1:0] rd_ctrl = {31'h0000_0000, fwd_q};
  wire [sea_pkg::DATA_W-1:0] rd_det = {28'h000_0000, detect_q};
  wire [sea_pkg::DATA_W-1:0] rd_flt = {28'h000_0000, operation_error_bits_q};
  wire [sea_pkg::DATA_W-1:0] rd_mask = {28'h000_0000, mask_q};
  wire [sea_pkg::DATA_W-1:0] rd_info = {20'h0_0000, info_q};
  wire [sea_pkg::DATA_W-1:0] rd_stat = {29'h0000_0000, map_s2_q, test_s2_q, ini_busy};
  wire [sea_pkg::DATA_W-1:0] rd_mux = ({32{ra_ctrl}} & rd_ctrl) | ({32{ra_det}} & rd_det)
                                   | ({32{ra_flt}} & rd_flt) | ({32{ra_mask}} & rd_mask)
                                   | ({32{ra_info}} & rd_info) | ({32{ra_stat}} & rd_stat);

  sea_init u_init (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ini_start),
    .abort(abort_q),
    .busy(ini_busy),
    .addr(ini_addr),
    .done(ini_done)
  );

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign alarm_correctable = al_ce_q;
  assign alarm_uncorrectable = al_ue_q;
  assign alarm_address = al_ae_q;
  assign alarm_group0_flag10 = al_g10_q;
  assign alarm_group1_flag10 = al_g10_q;
  assign owner_correctable = own_ce_q;
  assign owner_uncorrectable = own_ue_q;
  assign owner_address = own_ae_q;
  assign init_busy = ini_busy;
  assign init_addr = ini_addr;
  assign irq = irq_q;

  // two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_s1_q <= 1'b0;
      test_s2_q <= 1'b0;
      test_s3_q <= 1'b0;
      map_s1_q <= 1'b0;
      map_s2_q <= 1'b0;
      map_s3_q <= 1'b0;
    end
    else
    begin
      test_s1_q <= memory_self_test;
      test_s2_q <= test_s1_q;
      test_s3_q <= test_s2_q;
      map_s1_q <= memory_map_select;
      map_s2_q <= map_s1_q;
      map_s3_q <= map_s2_q;
    end
  end

  // alarm pulses: one cycle, issued for the access that saw the error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      al_ce_q <= 1'b0;
      al_ue_q <= 1'b0;
      al_ae_q <= 1'b0;
      al_g10_q <= 1'b0;
      own_ce_q <= 1'b0;
      own_ue_q <= 1'b0;
      own_ae_q <= 1'b0;
    end
    else
    begin
      al_ce_q <= ev_ce && fwd_q;
      al_ue_q <= ev_ue && fwd_q;
      al_ae_q <= ev_ae && fwd_q;
      al_g10_q <= ev_crit && fwd_q;
      // owner notification is not gated by forwarding
      own_ce_q <= ev_ce;
      own_ue_q <= ev_ue;
      own_ae_q <= ev_ae;
    end
  end

  // sticky status, set wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detect_q <= sea_pkg::DET_RST;
      operation_error_bits_q <= sea_pkg::OPERATION_ERROR_BITS_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      detect_q <= (detect_q & ~det_clr) | det_set;
      operation_error_bits_q <= (operation_error_bits_q & ~operation_error_bits_clr) | operation_error_bits_set;
      irq_q <= |(detect_q & mask_q);
    end
  end

  // error info: zero only when no real error was captured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      info_q <= sea_pkg::INFO_RST;
    end
    else if (any_ev)
    begin
      info_q <= {info_code, mem_addr};
    end
    else if (wr_go && wa_info)
    begin
      info_q <= sea_pkg::INFO_RST;
    end
  end

  // control: boot_q starts one initialization after every device reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_q <= sea_pkg::CTRL_FWD_RST;
      mask_q <= sea_pkg::MASK_RST;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      boot_q <= 1'b1;
    end
    else
    begin
      boot_q <= 1'b0;
      start_q <= wlo && wa_ctrl && w_data_q[sea_pkg::CTRL_START];
      abort_q <= wlo && wa_ctrl && w_data_q[sea_pkg::CTRL_ABORT];
      if (wlo && wa_ctrl)
      begin
        fwd_q <= w_data_q[sea_pkg::CTRL_FWD];
      end
      if (wlo && wa_mask)
      begin
        mask_q <= w_data_q[sea_pkg::DET_W-1:0];
      end
    end
  end

  // write address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_full_q <= 1'b0;
      end
      if (w_take)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_full_q <= 1'b0;
      end
    end
  end

  // write response and read answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= sea_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= sea_pkg::RESP_OKAY;
      rdata_q <= '0;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wa_hit ? sea_pkg::RESP_OKAY : sea_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= ra_hit ? sea_pkg::RESP_OKAY : sea_pkg::RESP_SLVERR;
        rdata_q <= rd_mux;
      end
      else if (s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : sea_guard

// ### sea_guard_properties.sv
/*
  concurrent checks on the memory guard ports.
  assumes it is bound into sea_guard, one clock, synchronous reset.
*/
module sea_guard_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic mem_access,
  input wire logic mem_write,
  input wire logic ecc_correctable,
  input wire logic ecc_uncorrectable,
  input wire logic address_fault,
  input wire logic cpu_data_memory,
  input wire logic app_reset,
  input wire logic alarm_uncorrectable,
  input wire logic alarm_group0_flag10,
  input wire logic alarm_group1_flag10,
  input wire logic owner_correctable,
  input wire logic owner_uncorrectable,
  input wire logic owner_address,
  input wire logic init_busy,
  input wire logic [sea_pkg::MEM_AW-1:0] init_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ce_read;
    mem_access && !app_reset && !mem_write && ecc_correctable;
  endsequence
  sequence s_ue_read;
    mem_access && !app_reset && !mem_write && ecc_uncorrectable;
  endsequence
  sequence s_ae_any;
    mem_access && !app_reset && address_fault;
  endsequence
  a_ce_report: assert property (s_ce_read |=> owner_correctable) else $error("correctable read not reported");
  a_ue_report: assert property (s_ue_read |=> owner_uncorrectable) else $error("uncorrectable read not reported");
  a_ae_report: assert property (s_ae_any |=> owner_address) else $error("address fault not reported");
  a_owner_cause: assert property ((owner_correctable || owner_uncorrectable || owner_address)
    |-> $past(mem_access && !app_reset)) else $error("report without a taken access");
  a_alarm_owner: assert property (alarm_uncorrectable |-> owner_uncorrectable) else $error("alarm without owner report");
  a_flag_pair: assert property (alarm_group0_flag10 |-> alarm_group1_flag10 && alarm_uncorrectable
    && $past(cpu_data_memory)) else $error("group flags disagree");
  a_init_first: assert property ($rose(init_busy) |-> init_addr == '0) else $error("sweep not from zero");
  a_init_step: assert property (init_busy && $past(init_busy) |-> init_addr == $past(init_addr) + 10'h001)
    else $error("sweep skipped a word");
  a_init_end: assert property (init_busy && init_addr == sea_pkg::MEM_LAST |=> !init_busy || init_addr == '0)
    else $error("sweep ran past the end");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answered twice");
endmodule : sea_guard_properties

bind sea_guard sea_guard_properties u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .mem_access, .mem_write, .ecc_correctable, .ecc_uncorrectable, .address_fault, .cpu_data_memory, .app_reset,
  .alarm_uncorrectable, .alarm_group0_flag10, .alarm_group1_flag10, .owner_correctable, .owner_uncorrectable,
  .owner_address, .init_busy, .init_addr);

// ### sea_collector.sv
/*
  safety alarm collector model: counts alarm pulses, one per cycle.
  assumes alarms are single-cycle pulses on aclk.
*/
module sea_collector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alarm_correctable,
  input wire logic alarm_uncorrectable,
  input wire logic alarm_address,
  input wire logic alarm_group0_flag10,
  input wire logic alarm_group1_flag10,
  output logic [7:0] ce_cnt,
  output logic [7:0] ue_cnt,
  output logic [7:0] ae_cnt,
  output logic [7:0] fl_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ce_cnt <= 8'h00;
      ue_cnt <= 8'h00;
      ae_cnt <= 8'h00;
      fl_cnt <= 8'h00;
    end
    else
    begin
      ce_cnt <= ce_cnt + {7'h00, alarm_correctable};
      ue_cnt <= ue_cnt + {7'h00, alarm_uncorrectable};
      ae_cnt <= ae_cnt + {7'h00, alarm_address};
      fl_cnt <= fl_cnt + {7'h00, alarm_group0_flag10 & alarm_group1_flag10};
    end
  end
endmodule : sea_collector

// ### sram_error_alarm_reporting_tb_top.sv
/*
  self-checking bench for the memory guard: axi4-lite tasks, sram access
  stimulus, collector model. assumes sea_pkg and sea_guard are compiled first.
*/
module sram_error_alarm_reporting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [sea_pkg::ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [sea_pkg::DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic mem_access = 1'b0, mem_write = 1'b0, ecc_correctable = 1'b0, ecc_uncorrectable = 1'b0, address_fault = 1'b0;
  logic cpu_data_memory = 1'b0, app_reset = 1'b0, memory_self_test = 1'b0, memory_map_select = 1'b0;
  logic [sea_pkg::MEM_AW-1:0] mem_addr = 10'h000, init_addr;
  logic alarm_correctable, alarm_uncorrectable, alarm_address, alarm_group0_flag10, alarm_group1_flag10;
  logic owner_correctable, owner_uncorrectable, owner_address, init_busy, irq;
  logic [7:0] ce_cnt, ue_cnt, ae_cnt, fl_cnt;
  int errors = 0;
  int comparisons = 0;
  int own_cnt = 0;

  sea_guard dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_access, .mem_write, .mem_addr,
    .ecc_correctable, .ecc_uncorrectable, .address_fault, .cpu_data_memory, .app_reset, .memory_self_test,
    .memory_map_select, .alarm_correctable, .alarm_uncorrectable, .alarm_address, .alarm_group0_flag10,
    .alarm_group1_flag10, .owner_correctable, .owner_uncorrectable, .owner_address, .init_busy, .init_addr, .irq);
  sea_collector u_coll (.aclk, .aresetn, .alarm_correctable, .alarm_uncorrectable, .alarm_address,
    .alarm_group0_flag10, .alarm_group1_flag10, .ce_cnt, .ue_cnt, .ae_cnt, .fl_cnt);

  initial forever #12.5 aclk = ~aclk;

  // counts owner reports of every kind, forwarded or not
  always @(posedge aclk)
    if (!aresetn)
      own_cnt <= 0;
    else
      own_cnt <= own_cnt + int'(owner_correctable) + int'(owner_uncorrectable) + int'(owner_address);

  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo;
    errors++;
    $display("BAD %0t wait ran out", $time);
    test_done();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    if (s_axi_bvalid !== 1'b1)
      tmo();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    if (s_axi_rvalid !== 1'b1)
      tmo();
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask : rc

  task automatic clr;
    wr(sea_pkg::OFF_DETECT, 32'hF);
    wr(sea_pkg::OFF_FAULT, 32'hF);
    wr(sea_pkg::OFF_INFO, 32'h0);
  endtask : clr

  // n back-to-back accesses, then two idle cycles for the pulses to land
  task automatic acc(input logic w, input logic ce, input logic ue, input logic ae, input logic [9:0] a, input int n);
    @(posedge aclk);
    mem_access <= 1'b1;
    mem_write <= w;
    ecc_correctable <= ce;
    ecc_uncorrectable <= ue;
    address_fault <= ae;
    mem_addr <= a;
    repeat (n) @(posedge aclk);
    mem_access <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : acc

  task automatic wait_busy(input logic lv, input int lim);
    int n;
    n = 0;
    while (init_busy !== lv && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    if (init_busy !== lv)
      tmo();
  endtask : wait_busy

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 1100);
    rc(sea_pkg::OFF_DETECT, 32'h8);
    rc(sea_pkg::OFF_CTRL, 32'h1);
    rc(sea_pkg::OFF_MASK, 32'h0);
    rc(sea_pkg::OFF_FAULT, 32'h0);
    rc(sea_pkg::OFF_INFO, 32'h0);
    wr(sea_pkg::OFF_DETECT, 32'hF);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 10'h005, 1);
    acc(1'b1, 1'b1, 1'b0, 1'b0, 10'h006, 1);
    chk(32'(ce_cnt), 32'h1);
    rc(sea_pkg::OFF_DETECT, 32'h1);
    rc(sea_pkg::OFF_FAULT, 32'h8);
    rc(sea_pkg::OFF_INFO, 32'h405);
    clr();
    cpu_data_memory <= 1'b1;
    acc(1'b0, 1'b0, 1'b1, 1'b0, 10'h010, 2);
    cpu_data_memory <= 1'b0;
    chk(32'(ue_cnt), 32'h2);
    chk(32'(fl_cnt), 32'h2);
    rc(sea_pkg::OFF_FAULT, 32'h1);
    clr();
    acc(1'b1, 1'b0, 1'b0, 1'b1, 10'h3FF, 1);
    chk(32'(ae_cnt), 32'h1);
    rc(sea_pkg::OFF_INFO, 32'hFFF);
    clr();
    wr(sea_pkg::OFF_CTRL, 32'h0);
    acc(1'b0, 1'b0, 1'b1, 1'b0, 10'h020, 1);
    chk(32'(ue_cnt), 32'h2);
    rc(sea_pkg::OFF_DETECT, 32'h2);
    chk(own_cnt, 32'h5);
    wr(sea_pkg::OFF_CTRL, 32'h1);
    wr(sea_pkg::OFF_MASK, 32'h2);
    rc(sea_pkg::OFF_MASK, 32'h2);
    chk(32'(irq), 32'h1);
    clr();
    rc(sea_pkg::OFF_DETECT, 32'h0);
    chk(32'(irq), 32'h0);
    wr(sea_pkg::OFF_MASK, 32'h0);
    app_reset <= 1'b1;
    cpu_data_memory <= 1'b1;
    acc(1'b0, 1'b0, 1'b1, 1'b1, 10'h030, 1);
    app_reset <= 1'b0;
    cpu_data_memory <= 1'b0;
    chk(32'(fl_cnt), 32'h2);
    rc(sea_pkg::OFF_FAULT, 32'h0);
    rc(sea_pkg::OFF_INFO, 32'h0);
    rc(8'h20, 32'h0);
    chk(32'(resp), 32'(sea_pkg::RESP_SLVERR));
    wr(8'h20, 32'hFFFFFFFF);
    chk(32'(resp), 32'(sea_pkg::RESP_SLVERR));
    wr(sea_pkg::OFF_CTRL, 32'h3);
    wait_busy(1'b1, 10);
    wr(sea_pkg::OFF_CTRL, 32'h5);
    wait_busy(1'b0, 10);
    rc(sea_pkg::OFF_DETECT, 32'h0);
    memory_self_test <= 1'b1;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 1100);
    rc(sea_pkg::OFF_DETECT, 32'h8);
    wr(sea_pkg::OFF_DETECT, 32'hF);
    memory_map_select <= 1'b1;
    wait_busy(1'b1, 10);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 10'h040, 1);
    chk(32'(ce_cnt), 32'h2);
    rc(sea_pkg::OFF_STAT, 32'h7);
    wait_busy(1'b0, 1100);
    rc(sea_pkg::OFF_DETECT, 32'h9);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 1);
    chk(own_cnt, 32'h6);
    test_done();
  end
endmodule : sram_error_alarm_reporting_tb_top
